// *** erdl_pkg.sv ***
// erdl_pkg: constants and types of the register default loader
package erdl_pkg;
  // ****************************************
  // timing
  // ****************************************
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned SCL_HZ = 100_000;
  localparam int unsigned QTR_PER_BIT = 4;
  localparam int unsigned QTR_CYC = CLK_HZ / (QTR_PER_BIT * SCL_HZ);
  localparam logic [8:0] QTR_LAST = 9'(QTR_CYC - 1);
  // ****************************************
  // serial bus framing
  // ****************************************
  localparam logic [6:0] EE_DEV_ADDR = 7'h50;
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam logic [1:0] BYTE_DEVW = 2'h0;
  localparam logic [1:0] BYTE_WADR = 2'h1;
  localparam logic [1:0] BYTE_DEVR = 2'h2;
  localparam logic [1:0] BYTE_DATA = 2'h3;
  localparam logic [1:0] PH_LOW0 = 2'h0;
  localparam logic [1:0] PH_HIGH = 2'h1;
  localparam logic [1:0] PH_MID = 2'h2;
  localparam logic [1:0] PH_LOW1 = 2'h3;
  // ****************************************
  // load map
  // ****************************************
  localparam logic [7:0] ROM_SYSCTL_F1 = 8'h0D;
  localparam logic [7:0] ROM_FEVT_F1 = 8'h1C;
  localparam logic [7:0] ROM_CARD_ID = 8'h1D;
  localparam logic [7:0] ROM_GCTRL = 8'h1E;
  localparam logic [7:0] ROM_GPO = 8'h21;
  localparam logic [2:0] LD_LAST_IDX = 3'h4;
  localparam logic [7:0] SYSCTL_LOAD_MASK = 8'h04;
  localparam logic [7:0] GPO_LOAD_MASK = 8'h1F;
  localparam int unsigned FEVT_SRC_BIT = 3;
  localparam int unsigned FEVT_LOAD_BIT = 27;
  // ****************************************
  // wishbone map and fields
  // ****************************************
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_SYSCTL = 8'h08;
  localparam logic [7:0] REG_FEVT = 8'h0C;
  localparam logic [7:0] REG_CARD_ID = 8'h10;
  localparam logic [7:0] REG_GCTRL = 8'h14;
  localparam logic [7:0] REG_GPO = 8'h18;
  localparam int unsigned CTRL_AUTO_BIT = 0;
  localparam int unsigned CTRL_KICK_BIT = 1;
  localparam int unsigned STAT_DONE_BIT = 1;
  localparam int unsigned STAT_ERR_BIT = 2;
  localparam logic CTRL_AUTO_RST = 1'b1;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [31:0] WORD_RST = 32'h0000_0000;
  typedef enum logic [2:0] {SB_IDLE = 3'b000, SB_START = 3'b001, SB_BIT = 3'b010, SB_STOP = 3'b011} erdl_sb_state_t;
  typedef enum logic [1:0] {LD_IDLE = 2'b00, LD_REQ = 2'b01, LD_WAIT = 2'b10} erdl_ld_state_t;
endpackage : erdl_pkg

// *** erdl_sbus_reader.sv ***
// erdl_sbus_reader: two-wire random read of one eeprom byte
module erdl_sbus_reader
#(
  parameter logic [8:0] QTR_LAST_P = erdl_pkg::QTR_LAST
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic rd_start_i,
  input wire logic [7:0] rd_offset_i,
  output logic rd_busy_o,
  output logic rd_done_o,
  output logic rd_nack_o,
  output logic [7:0] rd_data_o,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_o,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o
);
  import erdl_pkg::*;
  // ****************************************
  // state
  // ****************************************
  erdl_sb_state_t state_reg;
  logic [8:0] qcnt_reg;
  logic [1:0] phase_reg;
  logic [3:0] bit_reg;
  logic [1:0] byte_reg;
  logic [7:0] shift_reg;
  logic [7:0] off_reg;
  logic samp_reg;
  logic nack_reg;
  logic done_reg;
  logic [7:0] data_reg;
  logic scl_oe_reg;
  logic sda_oe_reg;
  logic tick;
  logic stall;
  logic tx_byte;
  logic ack_slot;
  logic scl_low;
  logic sda_low;

  function automatic logic [7:0] byte_val(input logic [1:0] b, input logic [7:0] off);
    case (b)
      BYTE_DEVW: byte_val = {EE_DEV_ADDR, 1'b0};
      BYTE_WADR: byte_val = off;
      BYTE_DEVR: byte_val = {EE_DEV_ADDR, 1'b1};
      default: byte_val = BYTE_RST;
    endcase
  endfunction : byte_val

  // ****************************************
  // pin decode
  // ****************************************
  // stall while a slave stretches the clock low
  assign stall = (state_reg != SB_IDLE) && (phase_reg == PH_HIGH) && !scl_oe_reg && !scl_i;
  assign tick = (state_reg != SB_IDLE) && !stall && (qcnt_reg == QTR_LAST_P);
  assign tx_byte = (byte_reg != BYTE_DATA);
  assign ack_slot = (bit_reg == BIT_ACK);
  assign scl_low = (state_reg == SB_BIT || state_reg == SB_START) ? (phase_reg == PH_LOW0 || phase_reg == PH_LOW1)
                 : (state_reg == SB_STOP) ? (phase_reg == PH_LOW0) : 1'b0;
  // the data byte ends with the ack slot released, a nack that ends the read
  assign sda_low = (state_reg == SB_BIT) ? (tx_byte && !ack_slot && !shift_reg[7])
                 : (state_reg == SB_START) ? phase_reg[1]
                 : (state_reg == SB_STOP) ? !phase_reg[1] : 1'b0;
  assign rd_busy_o = (state_reg != SB_IDLE);
  assign rd_done_o = done_reg;
  assign rd_nack_o = nack_reg;
  assign rd_data_o = data_reg;
  assign scl_oe_o = scl_oe_reg;
  assign sda_oe_o = sda_oe_reg;
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;

  // ****************************************
  // sequencer
  // ****************************************
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_reg <= SB_IDLE;
      qcnt_reg <= '0;
      phase_reg <= PH_LOW0;
      bit_reg <= '0;
      byte_reg <= BYTE_DEVW;
      shift_reg <= BYTE_RST;
      off_reg <= BYTE_RST;
      samp_reg <= 1'b0;
      nack_reg <= 1'b0;
      done_reg <= 1'b0;
      data_reg <= BYTE_RST;
      scl_oe_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
    end
    else
    begin
      scl_oe_reg <= scl_low;
      sda_oe_reg <= sda_low;
      done_reg <= 1'b0;
      if (state_reg == SB_IDLE)
      begin
        if (rd_start_i)
        begin
          state_reg <= SB_START;
          off_reg <= rd_offset_i;
          qcnt_reg <= '0;
          phase_reg <= PH_LOW0;
          byte_reg <= BYTE_DEVW;
          nack_reg <= 1'b0;
        end
      end
      else if (!stall)
        qcnt_reg <= tick ? '0 : qcnt_reg + 9'h001;
      if (tick)
      begin
        phase_reg <= phase_reg + 2'h1;
        if (phase_reg == PH_MID)
          samp_reg <= sda_i;
        if (phase_reg == PH_LOW1)
        begin
          case (state_reg)
            SB_START:
            begin
              state_reg <= SB_BIT;
              bit_reg <= '0;
              shift_reg <= byte_val(byte_reg, off_reg);
            end
            SB_BIT:
            begin
              if (!ack_slot)
              begin
                bit_reg <= bit_reg + 4'h1;
                shift_reg <= {shift_reg[6:0], samp_reg};
              end
              else if (tx_byte && samp_reg)
              begin
                nack_reg <= 1'b1;
                state_reg <= SB_STOP;
              end
              else if (byte_reg == BYTE_WADR)
              begin
                byte_reg <= BYTE_DEVR;
                state_reg <= SB_START;
              end
              else if (byte_reg == BYTE_DATA)
              begin
                data_reg <= shift_reg;
                state_reg <= SB_STOP;
              end
              else
              begin
                byte_reg <= byte_reg + 2'h1;
                bit_reg <= '0;
                shift_reg <= byte_val(byte_reg + 2'h1, off_reg);
              end
            end
            SB_STOP:
            begin
              state_reg <= SB_IDLE;
              done_reg <= 1'b1;
            end
            default: state_reg <= SB_IDLE;
          endcase
        end
      end
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  AST_SLAVE_ADDR: assert property (
    (state_reg == SB_BIT && byte_reg == BYTE_DEVW && bit_reg < 4'h7 && phase_reg == PH_HIGH)
    |-> (sda_oe_reg == !EE_DEV_ADDR[3'(6 - bit_reg)])
  ) else $error("device address bit driven wrong");
endmodule : erdl_sbus_reader

// *** erdl_loader_top.sv ***
// erdl_loader_top: power-up default loader with wishbone register access
//
// The register addresses and the Wishbone interface to the registers are this design's own decisions.
module erdl_loader_top
#(
  // quarter-bit count; only a bench shortens it, to keep runs brief
  parameter logic [8:0] QTR_LAST_P = erdl_pkg::QTR_LAST
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic hbus_rst_i,
  input wire logic sbus_present_i,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_o,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  output logic [7:0] sysctl_f1_o,
  output logic [31:0] force_event_f1_o,
  output logic [7:0] card_id_rev_o,
  output logic [7:0] gen_ctrl_o,
  output logic [7:0] gpo_o,
  output logic load_busy_o
);
  import erdl_pkg::*;
  // ****************************************
  // declarations
  // ****************************************
  erdl_ld_state_t ld_state_reg;
  logic [2:0] idx_reg;
  logic rd_start_reg;
  logic hrst_prev_reg;
  logic busy_reg;
  logic [7:0] last_off_reg;
  logic auto_reg;
  logic done_reg;
  logic err_reg;
  logic ack_reg;
  logic [31:0] dat_reg;
  logic [7:0] sysctl_reg;
  logic [31:0] fevt_reg;
  logic [7:0] card_reg;
  logic [7:0] gctrl_reg;
  logic [7:0] gpo_reg;
  logic rd_busy;
  logic rd_done;
  logic rd_nack;
  logic [7:0] rd_data;
  logic access;
  logic wr_en;
  logic trig;
  logic ld_ok;
  logic ld_last;
  logic [31:0] rd_mux;
  logic [31:0] fevt_load;

  function automatic logic [7:0] rom_off(input logic [2:0] idx);
    case (idx)
      3'h0: rom_off = ROM_SYSCTL_F1;
      3'h1: rom_off = ROM_FEVT_F1;
      3'h2: rom_off = ROM_CARD_ID;
      3'h3: rom_off = ROM_GCTRL;
      default: rom_off = ROM_GPO;
    endcase
  endfunction : rom_off

  function automatic logic [31:0] lanes(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
    for (int i = 0; i < 4; i++)
      lanes[i*8 +: 8] = sel[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
  endfunction : lanes

  function automatic logic [7:0] lane0(input logic [7:0] old, input logic [31:0] nw, input logic [3:0] sel);
    lane0 = sel[0] ? nw[7:0] : old;
  endfunction : lane0

  function automatic logic wr_hit(input logic en, input logic [7:0] a, input logic [7:0] r);
    wr_hit = en && (a == r);
  endfunction : wr_hit

  // ****************************************
  // serial reader
  // ****************************************
  erdl_sbus_reader
  #(
    .QTR_LAST_P(QTR_LAST_P)
  )
  u_reader
  (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .rd_start_i(rd_start_reg),
    .rd_offset_i(rom_off(idx_reg)),
    .rd_busy_o(rd_busy),
    .rd_done_o(rd_done),
    .rd_nack_o(rd_nack),
    .rd_data_o(rd_data),
    .scl_i(scl_i),
    .scl_o(scl_o),
    .scl_oe_o(scl_oe_o),
    .sda_i(sda_i),
    .sda_o(sda_o),
    .sda_oe_o(sda_oe_o)
  );

  // ****************************************
  // decode
  // ****************************************
  assign access = wb_cyc_i && wb_stb_i && !ack_reg;
  assign wr_en = access && wb_we_i;
  // a kick from software also needs the bus present, else the load would only fail
  assign trig = sbus_present_i && ((hrst_prev_reg && !hbus_rst_i && auto_reg)
              || (wr_hit(wr_en, wb_adr_i, REG_CTRL) && wb_sel_i[0] && wb_dat_i[CTRL_KICK_BIT]));
  assign ld_ok = (ld_state_reg == LD_WAIT) && rd_done && !rd_nack;
  assign ld_last = (idx_reg == LD_LAST_IDX);
  assign fevt_load = 32'(rd_data[FEVT_SRC_BIT]) << FEVT_LOAD_BIT;
  assign rd_mux = (wb_adr_i == REG_CTRL) ? {31'h0000_0000, auto_reg}
                : (wb_adr_i == REG_STATUS) ? {28'h000_0000, sbus_present_i, err_reg, done_reg, rd_busy}
                : (wb_adr_i == REG_SYSCTL) ? {24'h00_0000, sysctl_reg}
                : (wb_adr_i == REG_FEVT) ? fevt_reg
                : (wb_adr_i == REG_CARD_ID) ? {24'h00_0000, card_reg}
                : (wb_adr_i == REG_GCTRL) ? {24'h00_0000, gctrl_reg}
                : (wb_adr_i == REG_GPO) ? {24'h00_0000, gpo_reg} : WORD_RST;
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;
  assign sysctl_f1_o = sysctl_reg;
  assign force_event_f1_o = fevt_reg;
  assign card_id_rev_o = card_reg;
  assign gen_ctrl_o = gctrl_reg;
  assign gpo_o = gpo_reg;
  assign load_busy_o = busy_reg;

  // ****************************************
  // load sequencer
  // ****************************************
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ld_state_reg <= LD_IDLE;
      idx_reg <= '0;
      rd_start_reg <= 1'b0;
      hrst_prev_reg <= 1'b0;
      busy_reg <= 1'b0;
      last_off_reg <= BYTE_RST;
    end
    else
    begin
      hrst_prev_reg <= hbus_rst_i;
      rd_start_reg <= (ld_state_reg == LD_REQ);
      if (rd_start_reg)
        last_off_reg <= rom_off(idx_reg);
      case (ld_state_reg)
        LD_IDLE:
          if (trig)
          begin
            ld_state_reg <= LD_REQ;
            busy_reg <= 1'b1;
            idx_reg <= '0;
          end
        LD_REQ: ld_state_reg <= LD_WAIT;
        LD_WAIT:
          if (rd_done)
          begin
            ld_state_reg <= (rd_nack || ld_last) ? LD_IDLE : LD_REQ;
            busy_reg <= !(rd_nack || ld_last);
            idx_reg <= idx_reg + 3'h1;
          end
        default:
        begin
          ld_state_reg <= LD_IDLE;
          busy_reg <= 1'b0;
        end
      endcase
    end
  end

  // ****************************************
  // registers and wishbone
  // ****************************************
  // a load in the same cycle as a software write wins, as does a status set over its clear
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_reg <= 1'b0;
      dat_reg <= WORD_RST;
      auto_reg <= CTRL_AUTO_RST;
      done_reg <= 1'b0;
      err_reg <= 1'b0;
      sysctl_reg <= BYTE_RST;
      fevt_reg <= WORD_RST;
      card_reg <= BYTE_RST;
      gctrl_reg <= BYTE_RST;
      gpo_reg <= BYTE_RST;
    end
    else
    begin
      ack_reg <= access;
      if (access)
        dat_reg <= rd_mux;
      if (wr_hit(wr_en, wb_adr_i, REG_CTRL) && wb_sel_i[0])
        auto_reg <= wb_dat_i[CTRL_AUTO_BIT];
      done_reg <= (ld_ok && ld_last) || (done_reg && !(wr_hit(wr_en, wb_adr_i, REG_STATUS)
                  && wb_sel_i[0] && wb_dat_i[STAT_DONE_BIT]));
      err_reg <= (ld_state_reg == LD_WAIT && rd_done && rd_nack) || (err_reg && !(wr_hit(wr_en, wb_adr_i,
                 REG_STATUS) && wb_sel_i[0] && wb_dat_i[STAT_ERR_BIT]));
      if (ld_ok && idx_reg == 3'h0)
        sysctl_reg <= (sysctl_reg & ~SYSCTL_LOAD_MASK) | (rd_data & SYSCTL_LOAD_MASK);
      else if (wr_hit(wr_en, wb_adr_i, REG_SYSCTL))
        sysctl_reg <= lane0(sysctl_reg, wb_dat_i, wb_sel_i);
      if (ld_ok && idx_reg == 3'h1)
        fevt_reg <= (fevt_reg & ~(32'h1 << FEVT_LOAD_BIT)) | fevt_load;
      else if (wr_hit(wr_en, wb_adr_i, REG_FEVT))
        fevt_reg <= lanes(fevt_reg, wb_dat_i, wb_sel_i);
      if (ld_ok && idx_reg == 3'h2)
        card_reg <= rd_data;
      else if (wr_hit(wr_en, wb_adr_i, REG_CARD_ID))
        card_reg <= lane0(card_reg, wb_dat_i, wb_sel_i);
      if (ld_ok && idx_reg == 3'h3)
        gctrl_reg <= rd_data;
      else if (wr_hit(wr_en, wb_adr_i, REG_GCTRL))
        gctrl_reg <= lane0(gctrl_reg, wb_dat_i, wb_sel_i);
      if (ld_ok && ld_last)
        gpo_reg <= (gpo_reg & ~GPO_LOAD_MASK) | (rd_data & GPO_LOAD_MASK);
      else if (wr_hit(wr_en, wb_adr_i, REG_GPO))
        gpo_reg <= lane0(gpo_reg, wb_dat_i, wb_sel_i);
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  AST_START_ON_RESET: assert property (
    (ld_state_reg == LD_IDLE && hrst_prev_reg && !hbus_rst_i && sbus_present_i && auto_reg)
    |=> (ld_state_reg == LD_REQ && idx_reg == 3'h0) ##1 rd_start_reg
  ) else $error("load did not start after host bus reset");
  AST_SYSCTL_BIT: assert property (
    (ld_ok && idx_reg == 3'h0) |=> (sysctl_reg[2] == $past(rd_data[2]))
      && (sysctl_reg[7:3] == $past(sysctl_reg[7:3])) && (sysctl_reg[1:0] == $past(sysctl_reg[1:0]))
  ) else $error("system control load wrong");
  AST_FORCE_EVENT: assert property (
    (ld_ok && idx_reg == 3'h1) |=> (fevt_reg[27] == $past(rd_data[3])) && (fevt_reg[26:0] == $past(fevt_reg[26:0]))
  ) else $error("force event load wrong");
  AST_CARD_ID: assert property (
    (ld_ok && idx_reg == 3'h2) |=> (card_reg == $past(rd_data))
  ) else $error("identification load wrong");
  AST_GEN_CTRL: assert property (
    (ld_ok && idx_reg == 3'h3) |=> (gctrl_reg == $past(rd_data)) ##1 (ld_state_reg == LD_WAIT)
  ) else $error("general control load wrong");
  AST_GPO_BITS: assert property (
    (ld_ok && ld_last) |=> (gpo_reg[4:0] == $past(rd_data[4:0])) && $stable(gpo_reg[7:5]) && done_reg
  ) else $error("general-purpose output load wrong");
  AST_ASCENDING: assert property (
    (rd_start_reg && idx_reg != 3'h0) |-> (rom_off(idx_reg) > last_off_reg)
  ) else $error("rom offsets not ascending");
  AST_ERR_STOPS: assert property (
    (ld_state_reg == LD_WAIT && rd_done && rd_nack) |=> (ld_state_reg == LD_IDLE && err_reg) [*2]
  ) else $error("nack did not end the load");
  COV_FULL_LOAD: cover property (ld_ok && ld_last);
  COV_NACK: cover property (ld_state_reg == LD_WAIT && rd_done && rd_nack);
  COV_SW_KICK: cover property (ld_state_reg == LD_IDLE && trig && !hrst_prev_reg);
endmodule : erdl_loader_top

// *** erdl_ee_model.sv ***
// erdl_ee_model: behavioural serial eeprom answering random reads on the open-drain wires
module erdl_ee_model
(
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic nack_i,
  input wire logic slow_i,
  output logic scl_pull_o,
  output logic sda_pull_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // storage and trace
  // ****************************************
  logic [7:0] mem [256];
  logic [7:0] ptr_log [8];
  logic [7:0] sh;
  logic [7:0] ptr;
  logic [7:0] wr_adr;
  logic [7:0] rd_adr;
  logic rw;
  int bitc = 0;
  int phase = 3;
  int nlog = 0;
  initial
  begin
    scl_pull_o = 1'b0;
    sda_pull_o = 1'b0;
  end
  // ****************************************
  // start and stop detection
  // ****************************************
  always @(negedge sda_i)
  begin
    if (scl_i === 1'b1)
    begin
      // the scl fall that closes a start carries no bit
      bitc = -1;
      phase = 0;
      sda_pull_o = 1'b0;
    end
  end
  always @(posedge sda_i)
  begin
    if (scl_i === 1'b1)
      phase = 3;
  end
  always @(posedge scl_i)
  begin
    if (phase < 2 && bitc < 8)
      sh = {sh[6:0], sda_i};
  end
  // ****************************************
  // bit engine; data changes only while scl is low
  // ****************************************
  always @(negedge scl_i)
  begin
    if (phase < 3)
    begin
      bitc = bitc + 1;
      if (bitc == 8 && phase == 0)
      begin
        rw = sh[0];
        if (sh[0])
          rd_adr = sh;
        else
          wr_adr = sh;
        sda_pull_o = (sh[7:1] == 7'h50) && !nack_i;
        if (!sda_pull_o)
          phase = 3;
      end
      else if (bitc == 8 && phase == 1)
      begin
        ptr = sh;
        ptr_log[nlog[2:0]] = sh;
        nlog = nlog + 1;
        sda_pull_o = 1'b1;
      end
      else if (bitc == 8)
        sda_pull_o = 1'b0;
      else if (bitc == 9)
      begin
        bitc = 0;
        phase = (phase == 0) ? (rw ? 2 : 1) : 3;
        sda_pull_o = (phase == 2) ? ~mem[ptr][7] : 1'b0;
      end
      else if (phase == 2)
        sda_pull_o = ~mem[ptr][7 - bitc];
      // slow mode stretches the ack bit to exercise the master's wait
      if (slow_i && bitc == 8)
      begin
        scl_pull_o = 1'b1;
        #2000;
        scl_pull_o = 1'b0;
      end
    end
  end
endmodule : erdl_ee_model

// *** erdl_loader_top_tb_top.sv ***
// erdl_loader_top_tb_top: self-checking bench of the default loader
module erdl_loader_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import erdl_pkg::*;
  // ****************************************
  // signals
  // ****************************************
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0;
  logic hbus_rst_i = 1'b0;
  logic sbus_present_i = 1'b0;
  logic nack_en = 1'b0;
  logic slow_en = 1'b0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic scl_o, scl_oe_o, sda_o, sda_oe_o, ee_scl_pull, ee_sda_pull, load_busy_o;
  logic [7:0] sysctl_f1_o, card_id_rev_o, gen_ctrl_o, gpo_o;
  logic [31:0] force_event_f1_o;
  logic [31:0] rd;
  int error_cnt = 0;
  int cmp_count = 0;
  int cyc_cnt = 0;
  // pull-ups on both wires: a released line reads high
  wire scl_w = !(scl_oe_o | ee_scl_pull);
  wire sda_w = !(sda_oe_o | ee_sda_pull);
  logic [7:0] exp_ofs [5] = '{8'h0D, 8'h1C, 8'h1D, 8'h1E, 8'h21};
  always #2.5 clk_i = ~clk_i;
  // a ten-cycle quarter bit keeps five byte reads within a short run
  erdl_loader_top #(.QTR_LAST_P(9'h009))
  dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .hbus_rst_i(hbus_rst_i), .sbus_present_i(sbus_present_i), .scl_i(scl_w),
    .scl_o(scl_o), .scl_oe_o(scl_oe_o), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
    .sysctl_f1_o(sysctl_f1_o), .force_event_f1_o(force_event_f1_o), .card_id_rev_o(card_id_rev_o),
    .gen_ctrl_o(gen_ctrl_o), .gpo_o(gpo_o), .load_busy_o(load_busy_o));
  erdl_ee_model ee_u (.scl_i(scl_w), .sda_i(sda_w), .nack_i(nack_en), .slow_i(slow_en),
    .scl_pull_o(ee_scl_pull), .sda_pull_o(ee_sda_pull));
  // ****************************************
  // tasks
  // ****************************************
  task automatic results();
    $display("comparisons %0d errors %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : results
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // classic cycle: held until ack is sampled, released at that edge
  task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat, output logic [31:0] q);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 20);
    if (n >= 20)
      error_cnt++;
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    @(posedge clk_i);
  endtask : wb_xfer
  task automatic hb_pulse();
    hbus_rst_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    hbus_rst_i <= 1'b0;
    @(posedge clk_i);
  endtask : hb_pulse
  task automatic wait_idle();
    while (load_busy_o === 1'b1)
      @(posedge clk_i);
  endtask : wait_idle
  // ****************************************
  // hang guard: five byte reads with stretching need about 16k cycles
  // ****************************************
  always @(posedge clk_i)
  begin
    cyc_cnt++;
    if (cyc_cnt == 40000)
    begin
      error_cnt++;
      results();
    end
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    for (int i = 0; i < 256; i++)
      ee_u.mem[i] = 8'hFF;
    ee_u.mem[8'h0D] = 8'h5B;
    ee_u.mem[8'h1C] = 8'hF7;
    ee_u.mem[8'h1D] = 8'hC3;
    ee_u.mem[8'h1E] = 8'h96;
    ee_u.mem[8'h21] = 8'h35;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb_xfer(1'b0, REG_CTRL, 32'h0, rd);
    chk(rd, 32'h1);
    wb_xfer(1'b1, REG_SYSCTL, 32'hAF, rd);
    wb_xfer(1'b1, REG_FEVT, 32'h0800_1234, rd);
    wb_xfer(1'b1, REG_GPO, 32'hE0, rd);
    wb_xfer(1'b1, REG_CARD_ID, 32'h11, rd);
    wb_xfer(1'b0, 8'hFC, 32'h0, rd);
    chk(rd, 32'h0);
    hb_pulse();
    repeat (10) @(posedge clk_i);
    chk({31'h0, load_busy_o}, 32'h0);
    sbus_present_i <= 1'b1;
    slow_en <= 1'b1;
    hb_pulse();
    @(posedge clk_i);
    chk({31'h0, load_busy_o}, 32'h1);
    wait_idle();
    chk({24'h0, sysctl_f1_o}, 32'hAB);
    chk(force_event_f1_o, 32'h0000_1234);
    chk({24'h0, card_id_rev_o}, 32'hC3);
    chk({24'h0, gen_ctrl_o}, 32'h96);
    chk({24'h0, gpo_o}, 32'hF5);
    wb_xfer(1'b0, REG_GPO, 32'h0, rd);
    chk(rd, 32'hF5);
    for (int i = 0; i < 5; i++)
      chk({24'h0, ee_u.ptr_log[i]}, {24'h0, exp_ofs[i]});
    chk({24'h0, ee_u.wr_adr}, 32'hA0);
    chk({24'h0, ee_u.rd_adr}, 32'hA1);
    chk({31'h0, scl_oe_o}, 32'h0);
    chk({29'h0, scl_o, sda_o, sda_oe_o}, 32'h0);
    wb_xfer(1'b0, REG_STATUS, 32'h0, rd);
    chk(rd & 32'h2, 32'h2);
    wb_xfer(1'b1, REG_STATUS, 32'h6, rd);
    wb_xfer(1'b0, REG_STATUS, 32'h0, rd);
    chk(rd, 32'h8);
    // abort path: a slave that never acknowledges leaves every destination alone
    nack_en <= 1'b1;
    slow_en <= 1'b0;
    wb_xfer(1'b1, REG_CARD_ID, 32'h5A, rd);
    wb_xfer(1'b1, REG_CTRL, 32'h3, rd);
    repeat (3) @(posedge clk_i);
    wait_idle();
    wb_xfer(1'b0, REG_STATUS, 32'h0, rd);
    chk(rd & 32'h4, 32'h4);
    chk({24'h0, card_id_rev_o}, 32'h5A);
    chk({24'h0, sysctl_f1_o}, 32'hAB);
    results();
  end
endmodule : erdl_loader_top_tb_top
